/* logic/vpw_symbol_timing.sv */
// Symbol transmit timing and receive pulse classification for a single-wire VPW bus
// Summary of operation
// RULE_01: Counting tick period between 467 and 510 ns
// RULE_02: Normal mode tolerates 62-tick echo delay
// RULE_03: Fast mode tolerates 8-tick echo delay
// RULE_04: Normal short symbol 64 us, accept 37-91
// RULE_05: Normal long symbol 128 us, accept 100-157
// RULE_06: Normal SOF 200, EOF 280 with windows
// RULE_07: Normal break 768 sent, 249 received, idle 320
// RULE_08: Fast data symbols 16/32 us with windows
// RULE_09: Fast SOF 50, EOF 70, idle 80, break 63
// RULE_10: Separate rise and fall delay corrections
// RULE_11: Count ticks between edges, classify per mode
`timescale 1ns/1ps
`include "vpw_defs.svh"
module vpw_symbol_timing #(
    parameter int CORR_W = 6,
    parameter int CNT_W = 12
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fast_mode,
    input wire logic [CORR_W-1:0] i_rise_delay_correction,
    input wire logic [CORR_W-1:0] i_fall_delay_correction,
    input wire logic i_tx_req,
    input wire vpw_pkg::vpw_sym_t i_tx_sym,
    input wire logic i_tx_level,
    input wire logic i_bus_rx_line,
    output logic o_bus_tx_line,
    output logic o_tx_busy,
    output logic o_tx_done,
    output logic o_loop_err,
    output logic o_rx_valid,
    output vpw_pkg::vpw_sym_t o_rx_sym,
    output logic o_rx_active,
    output logic o_bus_idle
);
    import vpw_pkg::*;

    localparam int TICK_CYC = `VPW_TICK_CYC;
    localparam int TICK_NS = TICK_CYC * 1000 / `VPW_CLK_MHZ;

    if (TICK_NS < `VPW_TCCLK_MIN_NS || TICK_NS > `VPW_TCCLK_MAX_NS) begin : g_tick_chk
        $error("tick period out of range");
    end
    if (CNT_W < 11 || CNT_W > 16 || CORR_W < 4 || CORR_W > 8) begin : g_width_chk
        $error("counter or correction width unsupported");
    end

    function automatic logic [CNT_W-1:0] tk(input int us);
        tk = CNT_W'(`VPW_US2TK(us));
    endfunction

    // Nominal transmit width in ticks for a symbol in the selected mode
    function automatic logic [CNT_W-1:0] tx_nom(input vpw_sym_t s, input logic fast);
        case (s)
            VPW_SYM_SHORT: tx_nom = fast ? tk(`VPW_TX_SHORT_F_US) : tk(`VPW_TX_SHORT_N_US);
            VPW_SYM_LONG: tx_nom = fast ? tk(`VPW_TX_LONG_F_US) : tk(`VPW_TX_LONG_N_US);
            VPW_SYM_SOF: tx_nom = fast ? tk(`VPW_TX_SOF_F_US) : tk(`VPW_TX_SOF_N_US);
            VPW_SYM_EOF: tx_nom = fast ? tk(`VPW_TX_EOF_F_US) : tk(`VPW_TX_EOF_N_US);
            default: tx_nom = tk(`VPW_TX_BRK_US);
        endcase
    endfunction

    function automatic logic in_win(input logic [CNT_W-1:0] c, input int lo, input int hi);
        in_win = (c >= tk(lo)) && (c <= tk(hi));
    endfunction

    // Classify a finished pulse by level and width against the mode's windows
    function automatic vpw_sym_t classify(input logic act, input logic [CNT_W-1:0] c, input logic fast);
        classify = VPW_SYM_INVALID;
        if (fast) begin
            if (in_win(c, `VPW_RX_SHORT_LO_F_US, `VPW_RX_SHORT_HI_F_US)) begin
                classify = VPW_SYM_SHORT;
            end else if (in_win(c, `VPW_RX_LONG_LO_F_US, `VPW_RX_LONG_HI_F_US)) begin
                classify = VPW_SYM_LONG;
            end else if (act && in_win(c, `VPW_RX_SOF_LO_F_US, `VPW_RX_SOF_HI_F_US)) begin
                classify = VPW_SYM_SOF;
            end else if (act && c >= tk(`VPW_RX_BRK_F_US)) begin
                classify = VPW_SYM_BREAK;
            end else if (!act && in_win(c, `VPW_RX_EOF_LO_F_US, `VPW_RX_EOF_HI_F_US)) begin
                classify = VPW_SYM_EOF;
            end
        end else begin
            if (in_win(c, `VPW_RX_SHORT_LO_N_US, `VPW_RX_SHORT_HI_N_US)) begin
                classify = VPW_SYM_SHORT;
            end else if (in_win(c, `VPW_RX_LONG_LO_N_US, `VPW_RX_LONG_HI_N_US)) begin
                classify = VPW_SYM_LONG;
            end else if (act && in_win(c, `VPW_RX_SOF_LO_N_US, `VPW_RX_SOF_HI_N_US)) begin
                classify = VPW_SYM_SOF;
            end else if (act && c >= tk(`VPW_RX_BRK_N_US)) begin
                classify = VPW_SYM_BREAK;
            end else if (!act && in_win(c, `VPW_RX_EOF_LO_N_US, `VPW_RX_EOF_HI_N_US)) begin
                classify = VPW_SYM_EOF;
            end
        end
    endfunction

    // Tick divider: every width is counted in tick periods
    logic [7:0] div_q;
    logic tick_q;
    wire div_end = (div_q == 8'(TICK_CYC - 1));
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_end ? 8'h00 : div_q + 8'h01; // RULE_01
            tick_q <= div_end;
        end
    end

    // Receive pin synchroniser; the third stage is the edge reference
    logic rx_s1_q, rx_s2_q, rx_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_q <= 1'b0;
        end else begin
            rx_s1_q <= i_bus_rx_line;
            rx_s2_q <= rx_s1_q;
            rx_q <= rx_s2_q;
        end
    end
    wire rx_edge = rx_s2_q != rx_q;

    // Receive width counter, saturating so a stuck line cannot wrap into a window
    logic [CNT_W-1:0] rcnt_q;
    wire rcnt_sat = &rcnt_q;
    wire [CNT_W-1:0] idle_tk = i_fast_mode ? tk(`VPW_RX_IDLE_F_US) : tk(`VPW_RX_IDLE_N_US);
    wire vpw_sym_t rx_class = classify(rx_q, rcnt_q, i_fast_mode);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rcnt_q <= '0;
            o_rx_valid <= 1'b0;
            o_rx_sym <= VPW_SYM_INVALID;
            o_rx_active <= 1'b0;
            o_bus_idle <= 1'b0;
        end else begin
            o_rx_valid <= rx_edge; // RULE_11
            if (rx_edge) begin
                rcnt_q <= '0;
                o_rx_sym <= rx_class; // RULE_11
                o_rx_active <= rx_q;
            end else if (tick_q && !rcnt_sat) begin
                rcnt_q <= rcnt_q + 1'b1;
            end
            o_bus_idle <= !rx_q && !rx_edge && (rcnt_q >= idle_tk); // RULE_07 RULE_09
        end
    end

    // Transmit: drive level, wait for echo, then time the width from the echo edge or from the echo timeout
    vpw_tx_state_t st_q;
    logic [CNT_W-1:0] tcnt_q;
    logic [CNT_W-1:0] target_q;
    wire tx_act = (i_tx_sym == VPW_SYM_SOF) || (i_tx_sym == VPW_SYM_BREAK) ||
                  ((i_tx_sym != VPW_SYM_EOF) && i_tx_level);
    // Active width seen on the bus grows by fall delay and shrinks by rise delay
    wire [CNT_W-1:0] add_c = CNT_W'(tx_act ? i_rise_delay_correction : i_fall_delay_correction);
    wire [CNT_W-1:0] sub_c = CNT_W'(tx_act ? i_fall_delay_correction : i_rise_delay_correction);
    wire [CNT_W-1:0] nom_w = tx_nom(i_tx_sym, i_fast_mode);
    wire [CNT_W-1:0] tgt_raw = nom_w + add_c;
    wire [CNT_W-1:0] tgt_w = (tgt_raw > sub_c) ? tgt_raw - sub_c : CNT_W'(1);
    wire [CNT_W-1:0] echo_lim = i_fast_mode ? CNT_W'(`VPW_ECHO_F_TK) : CNT_W'(`VPW_ECHO_N_TK);
    wire echo_seen = rx_s2_q == o_bus_tx_line;
    wire start_ok = i_tx_req && (st_q == VPW_TX_IDLE);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= VPW_TX_IDLE;
            tcnt_q <= '0;
            target_q <= '0;
            o_bus_tx_line <= 1'b0;
            o_tx_busy <= 1'b0;
            o_tx_done <= 1'b0;
            o_loop_err <= 1'b0;
        end else begin
            o_tx_done <= 1'b0;
            o_loop_err <= 1'b0;
            case (st_q)
                VPW_TX_IDLE: begin
                    if (start_ok) begin
                        o_bus_tx_line <= tx_act;
                        target_q <= tgt_w; // RULE_10
                        tcnt_q <= '0;
                        o_tx_busy <= 1'b1;
                        st_q <= VPW_TX_ECHO;
                    end
                end
                VPW_TX_ECHO: begin
                    if (echo_seen) begin
                        tcnt_q <= '0;
                        st_q <= VPW_TX_HOLD;
                    end else if (tick_q) begin
                        if (tcnt_q >= echo_lim) begin
                            // Timing restarts from the echo timeout when the echo never returns
                            o_loop_err <= 1'b1; // RULE_02 RULE_03
                            tcnt_q <= '0;
                            st_q <= VPW_TX_HOLD;
                        end else begin
                            tcnt_q <= tcnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    if (tick_q) begin
                        if (tcnt_q + 1'b1 >= target_q) begin
                            o_tx_done <= 1'b1; // RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
                            o_tx_busy <= 1'b0;
                            st_q <= VPW_TX_IDLE;
                        end else begin
                            tcnt_q <= tcnt_q + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    tick_period_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(tick_q) |=> !tick_q [*8]) else $error("tick period too short"); // RULE_01
    echo_limit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == VPW_TX_ECHO) |-> (tcnt_q <= echo_lim)) else $error("echo wait overran"); // RULE_02
    echo_fast_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q == VPW_TX_ECHO && i_fast_mode) |-> (tcnt_q <= CNT_W'(`VPW_ECHO_F_TK))) else $error("fast echo overran"); // RULE_03
    hold_width_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_tx_done |-> ($past(tcnt_q) + 1'b1 >= $past(target_q))) else $error("symbol ended early"); // RULE_04
    line_steady_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q != VPW_TX_IDLE) |=> $stable(o_bus_tx_line)) else $error("line moved mid symbol"); // RULE_05
    sof_class_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_rx_valid && o_rx_sym == VPW_SYM_SOF) |-> o_rx_active) else $error("passive SOF"); // RULE_06
    idle_passive_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_bus_idle |-> !o_rx_active || !$past(rx_q)) else $error("idle while active"); // RULE_07
    edge_report_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_edge |=> o_rx_valid && (o_rx_active == $past(rx_q))) else $error("edge not reported"); // RULE_11
    corr_apply_a: assert property (@(posedge i_clk) disable iff (i_rst)
        start_ok |=> (target_q == $past(tgt_w))) else $error("correction not applied"); // RULE_10
endmodule // vpw_symbol_timing

/* include/vpw_defs.svh */
// Timing constants for the variable-pulse-width symbol timing block
`ifndef VPW_DEFS_SVH
`define VPW_DEFS_SVH
`define VPW_CLK_MHZ 200
`define VPW_TCCLK_NS 500
`define VPW_TCCLK_MIN_NS 467
`define VPW_TCCLK_MAX_NS 510
`define VPW_TICK_CYC (`VPW_TCCLK_NS * `VPW_CLK_MHZ / 1000)
`define VPW_US2TK(us) ((us) * 1000 / `VPW_TCCLK_NS)
`define VPW_ECHO_N_TK 62
`define VPW_ECHO_F_TK 8
`define VPW_TX_SHORT_N_US 64
`define VPW_TX_LONG_N_US 128
`define VPW_TX_SOF_N_US 200
`define VPW_TX_EOF_N_US 280
`define VPW_TX_BRK_US 768
`define VPW_TX_SHORT_F_US 16
`define VPW_TX_LONG_F_US 32
`define VPW_TX_SOF_F_US 50
`define VPW_TX_EOF_F_US 70
`define VPW_RX_SHORT_LO_N_US 37
`define VPW_RX_SHORT_HI_N_US 91
`define VPW_RX_LONG_LO_N_US 100
`define VPW_RX_LONG_HI_N_US 157
`define VPW_RX_SOF_LO_N_US 170
`define VPW_RX_SOF_HI_N_US 230
`define VPW_RX_EOF_LO_N_US 249
`define VPW_RX_EOF_HI_N_US 320
`define VPW_RX_IDLE_N_US 320
`define VPW_RX_BRK_N_US 249
`define VPW_RX_SHORT_LO_F_US 10
`define VPW_RX_SHORT_HI_F_US 22
`define VPW_RX_LONG_LO_F_US 25
`define VPW_RX_LONG_HI_F_US 39
`define VPW_RX_SOF_LO_F_US 43
`define VPW_RX_SOF_HI_F_US 57
`define VPW_RX_EOF_LO_F_US 63
`define VPW_RX_EOF_HI_F_US 80
`define VPW_RX_IDLE_F_US 80
`define VPW_RX_BRK_F_US 63
`endif

/* include/vpw_pkg.sv */
// Types shared by the variable-pulse-width symbol timing block
package vpw_pkg;
    typedef enum logic [2:0] {
        VPW_SYM_INVALID,
        VPW_SYM_SHORT,
        VPW_SYM_LONG,
        VPW_SYM_SOF,
        VPW_SYM_EOF,
        VPW_SYM_BREAK
    } vpw_sym_t;
    typedef enum logic [1:0] {
        VPW_TX_IDLE,
        VPW_TX_ECHO,
        VPW_TX_HOLD
    } vpw_tx_state_t;
endpackage

/* sim/vpw_xcvr_model.sv */
// Bus transceiver and other-node model for the VPW symbol timing bench
`timescale 1ns/1ps
module vpw_xcvr_model #(
    parameter realtime LOOP_NS = 2500.0
) (
    input wire logic i_tx,
    input wire logic i_node,
    input wire logic i_mute,
    output logic o_rx
);
    logic echo_q = 1'b0;
    // Transport delay keeps every edge; loop delay stays inside the fast-mode limit
    always @(i_tx) echo_q <= #(LOOP_NS) i_tx;
    // Wired-or bus, mute drops our own echo to provoke a loop error
    assign o_rx = (echo_q & ~i_mute) | i_node;
endmodule // vpw_xcvr_model

/* sim/vpw_symbol_timing_tb.sv */
// Self-checking bench for the VPW symbol timing block
`timescale 1ns/1ps
`include "vpw_defs.svh"
module vpw_symbol_timing_tb;
    import vpw_pkg::*;
    localparam int T = `VPW_TICK_CYC;
    localparam logic [3:0] SKIP = 4'hf;
    localparam realtime TK_NS = `VPW_TCCLK_NS;
    localparam realtime ERR_F_NS = `VPW_ECHO_F_TK * TK_NS;
    localparam realtime ERR_N_NS = `VPW_ECHO_N_TK * TK_NS;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_fast_mode = 1'b1;
    logic [5:0] i_rise_delay_correction = 6'h00;
    logic [5:0] i_fall_delay_correction = 6'h00;
    logic i_tx_req = 1'b0;
    vpw_sym_t i_tx_sym = VPW_SYM_SHORT;
    logic i_tx_level = 1'b0;
    logic i_bus_rx_line;
    logic node = 1'b0;
    logic mute = 1'b0;
    logic o_bus_tx_line, o_tx_busy, o_tx_done, o_loop_err, o_rx_valid, o_rx_active, o_bus_idle;
    vpw_sym_t o_rx_sym;
    logic [3:0] exp_q[$];
    logic [3:0] e;
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'h75b05815;
    int n;
    int w;
    realtime t_req;
    realtime t_err;

    vpw_symbol_timing vpw_symbol_timing_inst (.i_clk(i_clk), .i_rst(i_rst), .i_fast_mode(i_fast_mode),
        .i_rise_delay_correction(i_rise_delay_correction), .i_fall_delay_correction(i_fall_delay_correction),
        .i_tx_req(i_tx_req), .i_tx_sym(i_tx_sym), .i_tx_level(i_tx_level), .i_bus_rx_line(i_bus_rx_line),
        .o_bus_tx_line(o_bus_tx_line), .o_tx_busy(o_tx_busy), .o_tx_done(o_tx_done), .o_loop_err(o_loop_err),
        .o_rx_valid(o_rx_valid), .o_rx_sym(o_rx_sym), .o_rx_active(o_rx_active), .o_bus_idle(o_bus_idle));
    vpw_xcvr_model vpw_xcvr_model_inst (.i_tx(o_bus_tx_line), .i_node(node), .i_mute(mute), .o_rx(i_bus_rx_line));

    task automatic fail(input string msg);
        err_count++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One symbol per request; done is awaited under a bound
    task automatic send(input vpw_sym_t s, input logic lvl, input logic [5:0] rc);
        @(posedge i_clk);
        #1;
        i_tx_req = 1'b1;
        i_tx_sym = s;
        i_tx_level = lvl;
        i_rise_delay_correction = rc;
        t_req = $realtime;
        @(posedge i_clk);
        #1;
        i_tx_req = 1'b0;
        comparisons++;
        if (o_bus_tx_line !== lvl || o_tx_busy !== 1'b1) fail("tx start");
        n = 0;
        while (o_tx_done !== 1'b1 && n < 300 * T) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        comparisons++;
        if (n >= 300 * T) fail("no tx done");
        comparisons++;
        if (o_tx_busy !== 1'b0) fail("busy after done");
    endtask

    // Another node drives the bus; the class of this pulse is expected at its end
    task automatic pulse(input logic lvl, input int ticks, input logic fm, input logic [3:0] ex);
        exp_q.push_back(ex);
        @(posedge i_clk);
        #1;
        node = lvl;
        i_fast_mode = fm;
        repeat (ticks * T) @(posedge i_clk);
        #1;
    endtask

    always @(posedge i_clk) begin
        #1;
        if (o_rx_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'h0;
            if (e != SKIP) begin
                comparisons++;
                if ({o_rx_active, o_rx_sym} !== e) fail("rx symbol");
            end
        end
        if (o_loop_err === 1'b1) begin
            t_err = $realtime;
            if (mute == 1'b0) fail("loop error with echo");
        end
    end

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    // Tests take about 100k cycles; the watchdog leaves some margin
    initial begin
        #(125000 * 5);
        fail("watchdog");
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        comparisons++;
        if (o_bus_tx_line !== 1'b0 || o_tx_busy !== 1'b0 || o_rx_sym !== VPW_SYM_INVALID) fail("reset");
        comparisons++;
        if (o_bus_idle !== 1'b0 || o_rx_valid !== 1'b0 || o_loop_err !== 1'b0) fail("reset flags");
        i_rst = 1'b0;
        $display("test reset done");
        exp_q.push_back(SKIP);
        // Rise correction stretches the start-of-frame out of its window
        send(VPW_SYM_SOF, 1'b1, 6'h0c);
        exp_q.push_back({1'b1, VPW_SYM_INVALID});
        send(VPW_SYM_SHORT, 1'b0, 6'h00);
        exp_q.push_back({1'b0, VPW_SYM_SHORT});
        send(VPW_SYM_LONG, 1'b1, 6'h00);
        exp_q.push_back({1'b1, VPW_SYM_LONG});
        send(VPW_SYM_EOF, 1'b0, 6'h00);
        exp_q.push_back(SKIP);
        repeat (25 * T) @(posedge i_clk);
        #1;
        comparisons++;
        if (o_bus_idle !== 1'b1) fail("bus idle");
        $display("test fast transmit done");
        w = 22 + $unsigned($random(seed)) % 15;
        pulse(1'b1, w, 1'b1, {1'b1, VPW_SYM_SHORT});
        pulse(1'b0, 52 + $unsigned($random(seed)) % 15, 1'b1, {1'b0, VPW_SYM_LONG});
        pulse(1'b1, 128, 1'b1, {1'b1, VPW_SYM_BREAK});
        pulse(1'b0, 30, 1'b1, {1'b0, VPW_SYM_SHORT});
        pulse(1'b1, 47, 1'b1, {1'b1, VPW_SYM_INVALID});
        pulse(1'b0, 78, 1'b0, {1'b0, VPW_SYM_SHORT});
        pulse(1'b1, 78, 1'b0, {1'b1, VPW_SYM_SHORT});
        pulse(1'b0, 10, 1'b0, SKIP);
        $display("test receive done");
        mute = 1'b1;
        i_fast_mode = 1'b1;
        // Fall correction shortens an active symbol, which keeps the muted tests brief
        i_fall_delay_correction = 6'h10;
        t_err = 0.0;
        send(VPW_SYM_SHORT, 1'b1, 6'h00);
        comparisons++;
        if (t_err - t_req < ERR_F_NS || t_err - t_req > ERR_F_NS + 2 * TK_NS) fail("loop error time");
        $display("test loop error done");
        i_fast_mode = 1'b0;
        i_fall_delay_correction = 6'h3f;
        t_err = 0.0;
        send(VPW_SYM_SHORT, 1'b1, 6'h00);
        comparisons++;
        if (t_err - t_req < ERR_N_NS || t_err - t_req > ERR_N_NS + 2 * TK_NS) fail("normal loop error time");
        $display("test normal loop error done");
        give_verdict();
    end
endmodule // vpw_symbol_timing_tb
